// *** core/srw_core.sv ***
// supervisor reset watchdog: reset generator, watchdog, wishbone slave
// assumes asynchronous pins, a 200 MHz clk_i, a classic wishbone master
//
// Summary of operation
// [R1] reset output goes low while the under-voltage indication is true
// [R2] after voltage recovers, reset stays low one reset timeout, then high
// [R3] under-voltage comes from an external comparator against a 1.22 V ref
// [R4] reset timeout is a configurable cycle count
// [R5] basic watchdog timeout is a separate configurable cycle count
// [R6] grounded watchdog timing node disables the watchdog entirely
// [R7] select low uses basic timeout, high multiplies it by 500
// [R8] any change on the select input clears the watchdog timer
// [R9] processor must toggle service input before the timeout elapses
// [R10] each service edge clears and restarts the watchdog timer
// [R11] watchdog timer held cleared while the sequencer holds reset (ST_POR, ST_HOLD)
// [R12] extended mode with service input floating disables the watchdog
// [R13] watchdog expiry asserts reset one timeout, repeating until serviced
// [R14] active-high reset output is the inverse of the active-low one
// [R15] async inputs pass two flops; edges found on synchronised samples
// [R16] counters on clk_i compare against configured cycle counts
`timescale 1ns/10ps
`include "srw_cfg.svh"
module srw_core #(
   parameter logic [39:0] RST_CYCLES = 40'(`SRW_RST_CYCLES), // R4
   parameter logic [39:0] WDG_CYCLES = 40'(`SRW_WDG_CYCLES)  // R5
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_b_i,
   input  wire logic                  under_volt_i,
   input  wire logic                  watchdog_select_i,
   input  wire logic                  watchdog_service_input_i,
   input  wire logic                  service_float_i,
   input  wire logic                  watchdog_time_set_gnd_i,
   input  wire srw_pkg::srw_wb_req_type wb_req_i,
   output logic [31:0]                wb_dat_o,
   output logic                       wb_ack_o,
   output logic                       reset_b_o,
   output logic                       reset_o
);
   import srw_pkg::*;

   localparam int CW = `SRW_CNT_W;
   localparam logic [15:0] EXT_MULT = 16'(`SRW_EXT_MULT);

   // two-flop synchronisers; stage a feeds only stage b
   srw_pins_type sync_a, sync_b, sync_c;
   logic flt_a, flt_b;
   // the grounded timing node is a pin as well, so it is synchronised too
   logic gnd_a, gnd_b;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync_a <= '0;
         sync_b <= '0;
         sync_c <= '0;
         flt_a  <= 1'b0;
         flt_b  <= 1'b0;
         gnd_a  <= 1'b0;
         gnd_b  <= 1'b0;
      end else begin
         sync_a <= {under_volt_i, watchdog_select_i,
                    watchdog_service_input_i}; // R3 R15
         sync_b <= sync_a; // R15
         sync_c <= sync_b;
         flt_a  <= service_float_i;
         flt_b  <= flt_a;
         gnd_a  <= watchdog_time_set_gnd_i;
         gnd_b  <= gnd_a;
      end
   end

   // edge detection on consecutive synchronised samples
   logic svc_edge, sel_edge, first_seen;
   assign svc_edge = first_seen && (sync_b.service != sync_c.service); // R15
   assign sel_edge = first_seen && (sync_b.wdg_sel != sync_c.wdg_sel); // R15

   // software control: bit0 watchdog enable, bit1 reset-out enable
   logic [31:0] ctrl, next_ctrl;
   logic        wdg_sw_en;
   assign wdg_sw_en = ctrl[0];

   function automatic logic [CW-1:0] wdg_limit(input logic ext);
      wdg_limit = ext ? CW'(WDG_CYCLES * EXT_MULT) : WDG_CYCLES; // R7
   endfunction

   // watchdog disable conditions
   logic wdg_off;
   assign wdg_off = gnd_b // R6
                  || (sync_b.wdg_sel && flt_b) // R12
                  || !wdg_sw_en;

   // reset sequencer
   srw_state_type state, next_state;
   logic [CW-1:0] rst_cnt, next_rst_cnt;
   logic [CW-1:0] wdg_cnt, next_wdg_cnt;
   logic          next_reset_b, next_first_seen;
   logic [15:0]   wdg_trips, next_wdg_trips;
   logic          wdg_expire;
   logic          reset_hold;

   // an edge in the expiry cycle still counts as in time
   assign wdg_expire = (state == ST_RUN) && !wdg_off
                     && !svc_edge && !sel_edge // R8 R10
                     && (wdg_cnt >= wdg_limit(sync_b.wdg_sel) - 1'b1);

   always_comb begin
      next_state      = state;
      next_rst_cnt    = rst_cnt;
      next_wdg_cnt    = wdg_cnt;
      next_wdg_trips  = wdg_trips;
      next_first_seen = 1'b1;
      next_reset_b    = reset_hold;
      case (state)
         ST_POR, ST_HOLD: begin
            next_reset_b = 1'b0;
            next_wdg_cnt = '0; // R11
            if (sync_b.under_volt) begin
               next_rst_cnt = '0; // R1
            end else if (rst_cnt >= RST_CYCLES - 1'b1) begin
               next_state   = ST_RUN; // R2
               next_rst_cnt = '0;
               next_reset_b = 1'b1;
            end else begin
               next_rst_cnt = rst_cnt + 1'b1; // R16
            end
         end
         ST_RUN: begin
            next_reset_b = 1'b1;
            if (sync_b.under_volt) begin
               next_state   = ST_HOLD; // R1
               next_reset_b = 1'b0;
               next_wdg_cnt = '0;
            end else if (wdg_expire) begin
               next_state     = ST_HOLD; // R13
               next_reset_b   = 1'b0;
               next_wdg_cnt   = '0;
               next_wdg_trips = wdg_trips + 1'b1;
            end else if (svc_edge || sel_edge || wdg_off) begin
               next_wdg_cnt = '0; // R8 R10
            end else begin
               next_wdg_cnt = wdg_cnt + 1'b1; // R16
            end
         end
         default: begin
            next_state   = ST_POR;
            next_reset_b = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state      <= ST_POR;
         rst_cnt    <= '0;
         wdg_cnt    <= '0;
         wdg_trips  <= '0;
         first_seen <= 1'b0;
         reset_hold <= 1'b0;
      end else begin
         state      <= next_state;
         rst_cnt    <= next_rst_cnt;
         wdg_cnt    <= next_wdg_cnt;
         wdg_trips  <= next_wdg_trips;
         first_seen <= next_first_seen;
         reset_hold <= next_reset_b;
      end
   end

   // outputs from flops; ctrl bit1 low forces reset out asserted
   logic next_out_b;
   assign next_out_b = next_reset_b & next_ctrl[1];
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reset_b_o <= 1'b0;
         reset_o   <= 1'b1;
      end else begin
         reset_b_o <= next_out_b; // R1 R2
         reset_o   <= !next_out_b; // R14
      end
   end

   // wishbone classic slave, ack one cycle after request, dropped next
   logic        hit, next_ack, wr_ctrl;
   logic [31:0] next_dat;
   assign hit = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
   // a write lands on the edge at which the master samples ack high
   assign wr_ctrl = wb_ack_o && wb_req_i.cyc && wb_req_i.stb
                  && wb_req_i.we && wb_req_i.adr[7:0] == `SRW_ADR_CTRL
                  && wb_req_i.sel[0];
   always_comb begin
      next_ctrl = ctrl;
      next_ack  = hit;
      next_dat  = '0;
      if (wr_ctrl) begin
         next_ctrl = {30'h0, wb_req_i.dat[1:0]};
      end
      if (hit && !wb_req_i.we) begin
         case (wb_req_i.adr[7:0])
            `SRW_ADR_CTRL:   next_dat = ctrl;
            `SRW_ADR_STAT:   next_dat = {wdg_trips, 11'h0, flt_b,
                                         sync_b.wdg_sel, sync_b.under_volt,
                                         state == ST_RUN, reset_b_o};
            `SRW_ADR_RSTCNT: next_dat = rst_cnt[31:0];
            `SRW_ADR_WDGCNT: next_dat = wdg_cnt[31:0];
            default:         next_dat = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl     <= `SRW_CTRL_RST;
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         ctrl     <= next_ctrl;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // assertions
   AST_UV_RESET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      sync_b.under_volt |-> ##[1:2] !reset_b_o) // R1
      else $error("under-voltage did not assert reset");
   AST_HOLD_TIME: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(state == ST_RUN) |-> rst_cnt == '0 && $past(rst_cnt)
         == RST_CYCLES - 1'b1) // R2
      else $error("reset released before timeout");
   AST_TOGGLE_INV: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      reset_o == !reset_b_o) // R14
      else $error("reset outputs not complementary");
   AST_WDG_CLR_RST: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      state != ST_RUN |=> wdg_cnt == '0) // R11
      else $error("watchdog counted during reset");
   AST_SVC_CLR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      state == ST_RUN && svc_edge && !sync_b.under_volt && !wdg_expire
      |=> wdg_cnt == '0) // R10
      else $error("service edge did not clear timer");
   AST_SEL_CLR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      state == ST_RUN && sel_edge && !sync_b.under_volt && !wdg_expire
      |=> wdg_cnt == '0) // R8
      else $error("select change did not clear timer");
   AST_WDG_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      gnd_b && state == ST_RUN
      && !sync_b.under_volt |=> state == ST_RUN) // R6
      else $error("disabled watchdog caused reset");
   AST_FLOAT_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      sync_b.wdg_sel && flt_b |-> !wdg_expire) // R12
      else $error("floating service in extended mode expired");
   AST_EXPIRE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wdg_expire && !sync_b.under_volt |=> state == ST_HOLD
      && wdg_cnt == '0 && !reset_hold) // R13
      else $error("watchdog expiry did not reset");
   AST_LIMIT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wdg_cnt < wdg_limit(sync_b.wdg_sel) || $changed(sync_b.wdg_sel)) // R7
      else $error("watchdog count beyond limit");
   AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack stood longer than one cycle");
   AST_ACK_REQ: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged in one cycle");
   AST_ACK_ONLY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(wb_ack_o) |-> $past(wb_req_i.cyc && wb_req_i.stb))
      else $error("ack without a request");
   AST_RD_CTRL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      hit && !wb_req_i.we && wb_req_i.adr[7:0] == `SRW_ADR_CTRL
      |=> wb_dat_o == $past(ctrl))
      else $error("control read returned wrong data");
   AST_RD_STAT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      hit && !wb_req_i.we && wb_req_i.adr[7:0] == `SRW_ADR_STAT
      |=> wb_dat_o[0] == $past(reset_b_o))
      else $error("status read returned wrong reset level");
   AST_RD_HOLE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      hit && !wb_req_i.we && wb_req_i.adr[7:0] != `SRW_ADR_CTRL
      && wb_req_i.adr[7:0] != `SRW_ADR_STAT
      && wb_req_i.adr[7:0] != `SRW_ADR_RSTCNT
      && wb_req_i.adr[7:0] != `SRW_ADR_WDGCNT |=> wb_dat_o == '0)
      else $error("unmapped read returned nonzero");
   AST_CTRL_WR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_ctrl |=> ctrl == {30'h0, $past(wb_req_i.dat[1:0])})
      else $error("control write not taken");
   AST_CTRL_KEEP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !wr_ctrl |=> $stable(ctrl))
      else $error("control changed without a write");
   AST_OUT_FORCED: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !ctrl[1] |-> !reset_b_o)
      else $error("reset out released while forced");
   AST_OUT_MATCH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      reset_b_o == (reset_hold && ctrl[1])) // R1 R2
      else $error("reset out differs from sequencer");
   AST_HOLD_LOW: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      reset_hold == (state == ST_RUN)) // R1 R2
      else $error("reset level disagrees with state");
   AST_RST_RANGE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rst_cnt < RST_CYCLES) // R16
      else $error("reset counter beyond timeout");
   AST_UV_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      state != ST_RUN && sync_b.under_volt |=> rst_cnt == '0) // R1
      else $error("reset timer ran during under-voltage");
   AST_TRIPS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wdg_expire && !sync_b.under_volt
      |=> wdg_trips == $past(wdg_trips) + 16'h0001) // R13
      else $error("watchdog trip not counted");
   AST_GND_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      gnd_b |-> !wdg_expire) // R6
      else $error("grounded timing node still expired");
   AST_SW_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !ctrl[0] |-> !wdg_expire)
      else $error("software-disabled watchdog expired");
   AST_SEL_SAFE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      sel_edge |-> !wdg_expire) // R8
      else $error("select change caused expiry");
   AST_SVC_SAFE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      svc_edge |-> !wdg_expire) // R10
      else $error("service edge caused expiry");
   AST_COUNT_UP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      state == ST_RUN && !wdg_expire && !svc_edge && !sel_edge
      && !wdg_off && !sync_b.under_volt
      |=> wdg_cnt == $past(wdg_cnt) + 1'b1) // R16
      else $error("watchdog counter did not advance");
   COV_WDG_TRIP: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      wdg_expire);
   COV_SEL: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      state == ST_RUN && sel_edge);
   COV_FORCED: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      state == ST_RUN && !ctrl[1]);
   COV_UV: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      state == ST_RUN ##1 state == ST_HOLD && sync_b.under_volt);
   COV_SVC: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      state == ST_RUN && svc_edge);
endmodule // srw_core

// *** pkg/srw_cfg.svh ***
// constants for the supervisor reset watchdog
// assumes inclusion by the package and the core module only
`ifndef SRW_CFG_SVH
`define SRW_CFG_SVH
// reset timeout: 2.67 us per pF, nominal cap 1500 pF -> 4005 us
`define SRW_US_PER_PF_X100  267
`define SRW_RST_CAP_PF      1500
`define SRW_WDG_CAP_PF      1500
`define SRW_CLK_MHZ         200
`define SRW_RST_CYCLES      (`SRW_US_PER_PF_X100*`SRW_RST_CAP_PF*`SRW_CLK_MHZ/100)
`define SRW_WDG_CYCLES      (`SRW_US_PER_PF_X100*`SRW_WDG_CAP_PF*`SRW_CLK_MHZ/100)
`define SRW_EXT_MULT        500
`define SRW_CNT_W           40
// register map of the wishbone slave
`define SRW_ADR_CTRL        8'h00
`define SRW_ADR_STAT        8'h04
`define SRW_ADR_RSTCNT      8'h08
`define SRW_ADR_WDGCNT      8'h0C
`define SRW_CTRL_RST        32'h00000003
`endif

// *** pkg/srw_pkg.sv ***
// types for the supervisor reset watchdog
// assumes srw_cfg.svh on the include path
package srw_pkg;
`include "srw_cfg.svh"
   typedef enum logic [1:0] {ST_POR, ST_HOLD, ST_RUN} srw_state_type;
   typedef struct packed {
      logic under_volt;
      logic wdg_sel;
      logic service;
   } srw_pins_type;
   typedef struct packed {
      logic [31:0] adr;
      logic [31:0] dat;
      logic [3:0]  sel;
      logic        we;
      logic        cyc;
      logic        stb;
   } srw_wb_req_type;
endpackage

// *** bench/srw_proc_model.sv ***
// processor side model: services the watchdog line at a set period
// assumes the bench sets the period, run and float requests
`timescale 1ns/10ps
module srw_proc_model (
   input  wire logic       clk_i,
   input  wire logic       run_i,
   input  wire logic       float_i,
   input  wire logic [7:0] period_i,
   output logic            service_o,
   output logic            float_o
);
   logic [7:0] cnt = 8'h00;
   logic       lvl = 1'b0;
   always_ff @(posedge clk_i) begin
      cnt <= (cnt >= period_i) ? 8'h00 : cnt + 8'h01;
      if (run_i && !float_i && cnt == period_i)
         lvl <= ~lvl;
   end
   // a released line shows the inverse of the last level driven
   assign service_o = float_i ? ~lvl : lvl;
   assign float_o   = float_i;
endmodule // srw_proc_model

// *** bench/supervisor_reset_watchdog_test.sv ***
// testbench: reset generation, watchdog and register access
// assumes srw_core and the processor model; short cycle counts
`timescale 1ns/10ps
module supervisor_reset_watchdog_test;
   import srw_pkg::*;
   localparam int RC = 20;
   localparam int WC = 10;
   logic           clk_i   = 1'b0;
   logic           rst_b_i = 1'b0;
   logic           uv      = 1'b0;
   logic           sel     = 1'b0;
   logic           gnd     = 1'b0;
   logic           run     = 1'b1;
   logic           flt     = 1'b0;
   logic           svc;
   logic           svc_flt;
   logic           ack;
   logic           rb;
   logic           rh;
   logic [31:0]    dat;
   logic [31:0]    q;
   srw_wb_req_type req = '0;
   int             fail_count = 0;
   int             n_tests = 0;
   int             n;
   srw_proc_model srw_proc_model_i (.clk_i(clk_i), .run_i(run),
      .float_i(flt), .period_i(8'h04), .service_o(svc), .float_o(svc_flt));
   srw_core #(.RST_CYCLES(40'(RC)), .WDG_CYCLES(40'(WC))) srw_core_i (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .under_volt_i(uv),
      .watchdog_select_i(sel), .watchdog_service_input_i(svc),
      .service_float_i(svc_flt), .watchdog_time_set_gnd_i(gnd),
      .wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack),
      .reset_b_o(rb), .reset_o(rh));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rng(input int v, input int lo, input int hi);
      chk(32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(hi));
      chk({31'h0, rh}, {31'h0, ~rb});
   endtask
   // counts cycles until reset_b_o shows v, giving up after m
   task automatic wait_rb(input logic v, input int m, output int k);
      k = 0;
      while (rb !== v && k < m) begin
         @(negedge clk_i);
         k++;
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int k;
      @(posedge clk_i);
      req <= '{adr: {24'h0, a}, dat: d, sel: 4'hF, we: we,
               cyc: 1'b1, stb: 1'b1};
      k = 0;
      @(negedge clk_i);
      while (ack !== 1'b1 && k < 20) begin
         @(negedge clk_i);
         k++;
      end
      if (k >= 20) fail_count++;
      r = dat;
      @(posedge clk_i);
      req <= '0;
      @(posedge clk_i);
   endtask
   task automatic t_power;
      wait_rb(1'b1, RC + 10, n);
      rng(n, RC, RC + 8);
      $display("done power up");
   endtask
   task automatic t_under;
      @(posedge clk_i) uv <= 1'b1;
      wait_rb(1'b0, 6, n);
      rng(n, 0, 5);
      wait_rb(1'b1, 40, n);
      rng(n, 40, 40);
      @(posedge clk_i) uv <= 1'b0;
      wait_rb(1'b1, RC + 10, n);
      rng(n, RC, RC + 8);
      $display("done under voltage");
   endtask
   task automatic t_starve;
      @(posedge clk_i) run <= 1'b0;
      wait_rb(1'b0, WC + 10, n);
      rng(n, 0, WC + 8);
      wait_rb(1'b1, RC + 10, n);
      rng(n, RC - 2, RC + 4);
      wait_rb(1'b0, WC + 10, n);
      rng(n, WC - 1, WC + 4);
      @(posedge clk_i) run <= 1'b1;
      wait_rb(1'b1, RC + 10, n);
      wait_rb(1'b0, 50, n);
      rng(n, 50, 50);
      $display("done starve");
   endtask
   task automatic t_select;
      @(posedge clk_i) run <= 1'b0;
      repeat (10) begin
         @(posedge clk_i) sel <= ~sel;
         wait_rb(1'b0, 6, n);
         rng(n, 6, 6);
      end
      @(posedge clk_i) sel <= 1'b1;
      wait_rb(1'b0, 1000, n);
      rng(n, 1000, 1000);
      wait_rb(1'b0, 4100, n);
      rng(n, 3995, 4010);
      @(posedge clk_i) run <= 1'b1;
      sel <= 1'b0;
      wait_rb(1'b1, RC + 10, n);
      $display("done select");
   endtask
   task automatic t_off;
      @(posedge clk_i) sel <= 1'b1;
      flt <= 1'b1;
      wait_rb(1'b0, 6000, n);
      rng(n, 6000, 6000);
      @(posedge clk_i) sel <= 1'b0;
      flt <= 1'b0;
      gnd <= 1'b1;
      run <= 1'b0;
      wait_rb(1'b0, 200, n);
      rng(n, 200, 200);
      @(posedge clk_i) gnd <= 1'b0;
      run <= 1'b1;
      $display("done disable");
   endtask
   task automatic t_bus;
      wb(1'b0, 8'h00, 32'h0, q);
      chk(q, 32'h00000003);
      wb(1'b0, 8'h10, 32'h0, q);
      chk(q, 32'h00000000);
      wb(1'b0, 8'h04, 32'h0, q);
      chk({31'h0, q[0]}, 32'h00000001);
      wb(1'b1, 8'h00, 32'h00000001, q);
      wait_rb(1'b0, 4, n);
      rng(n, 0, 3);
      wb(1'b1, 8'h00, 32'h00000003, q);
      wait_rb(1'b1, RC + 10, n);
      rng(n, 0, RC + 9);
      $display("done bus");
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk_i);
      fail_count++;
      print_verdict();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_power();
      t_under();
      t_starve();
      t_select();
      t_off();
      t_bus();
      print_verdict();
   end
endmodule // supervisor_reset_watchdog_test
